/* File: logic/sdis_seq.sv */
`timescale 1ns/1ps
module sdis_seq
  import sdis_pkg::*;
#(
  parameter int unsigned PWRUP_CYC  = PWRUP_WAIT_CYC,
  parameter int unsigned INIT_REFS  = INIT_REF_CNT,
  parameter int unsigned BURST_REFS = BURST_REF_CNT
) (
  input  wire logic                CORE_CLK_I,
  input  wire logic                RST_N_I,
  input  wire logic                SR_ENTER_I,
  input  wire logic                SR_EXIT_I,
  input  wire logic                BURST_REF_EN_I,
  output logic                     SD_CLK_EN_O,
  output logic                     SD_CKE_O,
  output sdis_pkg::sdis_cmd_s      SD_CMD_O,
  output logic [1:0]               SD_BA_O,
  output logic [11:0]              SD_ADDR_O,
  output logic [1:0]               SD_DQM_O,
  output logic                     INIT_DONE_O,
  output logic                     SR_ACTIVE_O,
  output logic                     READY_O
);

  import sdis_pkg::*;

  localparam int unsigned CW = 16;

  initial
  begin
    if (INIT_REFS < 2) $error("sdis_seq: INIT_REFS below 2");
    if (PWRUP_CYC < 1 || PWRUP_CYC > 65535)
      $error("sdis_seq: PWRUP_CYC out of range");
    if (BURST_REFS < 1 || BURST_REFS > 65535)
      $error("sdis_seq: BURST_REFS out of range");
  end

  sdis_state_e   state;
  sdis_state_e   next_state;
  logic [CW-1:0] refs_left;
  logic [CW-1:0] next_refs_left;
  logic          sr_pending;
  logic          next_sr_pending;
  logic          wait_load;
  logic [CW-1:0] wait_value;
  logic          wait_done;
  logic          pwrup_armed;
  logic [CW-1:0] pwr_cnt;

  sdis_wait_cnt #(
    .WIDTH (CW)
  ) u_wait (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .load_i  (wait_load),
    .value_i (wait_value),
    .done_o  (wait_done)
  );

  // Burst refresh before entry and after exit reuses the refresh states
  // ST_PWRUP leaves only when the power counter has run out
  wire pwrup_hold = (state == ST_PWRUP) && (pwr_cnt != '0);
  wire burst_on   = BURST_REF_EN_I;
  wire go_sr      = (state == ST_IDLE) && SR_ENTER_I;

  always_comb
  begin
    next_state      = state;
    next_refs_left  = refs_left;
    next_sr_pending = sr_pending;
    wait_load       = 1'b0;
    wait_value      = '0;
    case (state)
      ST_PWRUP:
        if (!pwrup_hold)
          next_state = ST_PRE;
      ST_PRE:
      begin
        next_state = ST_PRE_W;
        wait_load  = 1'b1;
        wait_value = CW'(T_RP_CYC - 1);
      end
      ST_PRE_W:
        if (wait_done)
          next_state = ST_MRS;
      ST_MRS:
      begin
        next_state     = ST_MRS_W;
        wait_load      = 1'b1;
        wait_value     = CW'(T_MRD_CYC - 1);
        next_refs_left = CW'(INIT_REFS);
      end
      ST_MRS_W:
        if (wait_done)
          next_state = ST_REF;
      ST_REF:
      begin
        next_state     = ST_REF_W;
        wait_load      = 1'b1;
        wait_value     = CW'(T_RC_CYC - 1);
        next_refs_left = refs_left - 1'b1;
      end
      ST_REF_W:
        if (wait_done)
        begin
          if (refs_left != '0)
            next_state = ST_REF;
          else if (sr_pending)
            next_state = ST_SR_IN;
          else
            next_state = ST_IDLE;
        end
      ST_IDLE:
        if (go_sr)
        begin
          if (burst_on)
          begin
            next_state      = ST_REF;
            next_refs_left  = CW'(BURST_REFS);
            next_sr_pending = 1'b1;
          end
          else
            next_state = ST_SR_IN;
        end
      ST_SR_IN:
      begin
        next_state      = ST_SR_HOLD;
        next_sr_pending = 1'b0;
        wait_load       = 1'b1;
        wait_value      = CW'(T_RAS_CYC - 1);
      end
      ST_SR_HOLD:
        if (wait_done && SR_EXIT_I)
        begin
          next_state = ST_SR_CLK;
          wait_load  = 1'b1;
          wait_value = CW'(CLK_STABLE_CYC - 1);
        end
      ST_SR_CLK:
        if (wait_done)
        begin
          next_state = ST_SR_EXIT;
          wait_load  = 1'b1;
          wait_value = CW'(T_RC_CYC - 1);
        end
      ST_SR_EXIT:
        if (wait_done)
          next_state = ST_SR_TRC;
      ST_SR_TRC:
      begin
        if (burst_on)
        begin
          next_state     = ST_REF;
          next_refs_left = CW'(BURST_REFS);
        end
        else
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_PWRUP;
    endcase
  end

  // Power-up count is loaded by the arm_pwrup path: first cycle after reset loads it
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      pwrup_armed <= 1'b0;
    else
      pwrup_armed <= 1'b1;
  end

  wire arm_pwrup = !pwrup_armed;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state      <= ST_PWRUP;
      refs_left  <= '0;
      sr_pending <= 1'b0;
    end
    else if (arm_pwrup)
      state <= ST_PWRUP;
    else
    begin
      state      <= next_state;
      refs_left  <= next_refs_left;
      sr_pending <= next_sr_pending;
    end
  end

  // Power-up wait is held in a separate counter to keep the sequencer short
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      pwr_cnt <= '0;
    else if (arm_pwrup)
      pwr_cnt <= CW'(PWRUP_CYC);
    else if (pwr_cnt != '0)
      pwr_cnt <= pwr_cnt - 1'b1;
  end

  // Command decode: every wait state falls to NOP or deselect
  // CKE stays low while the restarted clock settles
  wire in_sr     = (state == ST_SR_IN) || (state == ST_SR_HOLD)
                || (state == ST_SR_CLK);
  wire in_exit   = (state == ST_SR_CLK) || (state == ST_SR_EXIT);
  wire clk_off   = (state == ST_SR_HOLD);

  sdis_cmd_s cmd_sel;
  assign cmd_sel = (state == ST_PRE)   ? CMD_PRE :
                   (state == ST_MRS)   ? CMD_MRS :
                   (state == ST_REF)   ? CMD_REF :
                   (state == ST_SR_IN) ? CMD_REF :
                   in_exit             ? CMD_DESEL :
                                         CMD_NOP;

  wire        cke_sel  = !in_sr;
  wire [11:0] addr_sel = (state == ST_MRS) ? MODE_WORD_RST :
                         (state == ST_PRE) ? 12'h4_00 : 12'h0_000;
  wire [1:0]  dqm_sel  = (state == ST_PWRUP || state == ST_PRE
                         || state == ST_PRE_W) ? 2'h3 : 2'h0;

  // A precharge while idle is never issued, so no row is open
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      SD_CLK_EN_O <= 1'b1;
      SD_CKE_O    <= 1'b1;
      SD_CMD_O    <= CMD_NOP;
      SD_BA_O     <= 2'h0;
      SD_ADDR_O   <= 12'h0_000;
      SD_DQM_O    <= 2'h3;
      INIT_DONE_O <= 1'b0;
      SR_ACTIVE_O <= 1'b0;
      READY_O     <= 1'b0;
    end
    else
    begin
      SD_CLK_EN_O <= !clk_off;
      SD_CKE_O    <= cke_sel;
      SD_CMD_O    <= cmd_sel;
      SD_BA_O     <= 2'h0;
      SD_ADDR_O   <= addr_sel;
      SD_DQM_O    <= dqm_sel;
      INIT_DONE_O <= INIT_DONE_O
                  || ((state == ST_REF_W) && wait_done
                      && refs_left == '0 && !sr_pending);
      SR_ACTIVE_O <= in_sr;
      READY_O     <= (next_state == ST_IDLE) && !arm_pwrup;
    end
  end

endmodule

/* File: logic/sdis_pkg.sv */
package sdis_pkg;

  // Clock period of the sequencer, in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 8000;

  // Power-up pause, in microseconds, and the derived cycle count
  localparam int unsigned PWRUP_WAIT_US  = 200;
  localparam int unsigned PWRUP_WAIT_CYC =
    (PWRUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Device timing in clocks (125 MHz grade)
  localparam int unsigned T_RP_CYC   = 3;
  localparam int unsigned T_RC_CYC   = 7;
  localparam int unsigned T_RAS_CYC  = 6;
  localparam int unsigned T_SRX_CYC  = 2;
  localparam int unsigned T_MRD_CYC  = 2;
  localparam int unsigned CLK_STABLE_CYC = 4;

  // Refresh counts
  localparam int unsigned INIT_REF_CNT  = 2;
  localparam int unsigned BURST_REF_CNT = 2048;

  // Mode word driven on the address bus during mode register set
  localparam logic [11:0] MODE_WORD_RST = 12'h0_022;
  // Address bit that selects all banks for precharge
  localparam int unsigned A10_POS = 10;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdis_cmd_s;

  localparam sdis_cmd_s CMD_NOP   = '{1'b0, 1'b1, 1'b1, 1'b1};
  localparam sdis_cmd_s CMD_DESEL = '{1'b1, 1'b1, 1'b1, 1'b1};
  localparam sdis_cmd_s CMD_PRE   = '{1'b0, 1'b0, 1'b1, 1'b0};
  localparam sdis_cmd_s CMD_MRS   = '{1'b0, 1'b0, 1'b0, 1'b0};
  localparam sdis_cmd_s CMD_REF   = '{1'b0, 1'b0, 1'b0, 1'b1};

  typedef enum logic [3:0] {
    ST_PWRUP   = 4'h0,
    ST_PRE     = 4'h1,
    ST_PRE_W   = 4'h2,
    ST_MRS     = 4'h3,
    ST_MRS_W   = 4'h4,
    ST_REF     = 4'h5,
    ST_REF_W   = 4'h6,
    ST_IDLE    = 4'h7,
    ST_SR_IN   = 4'h8,
    ST_SR_HOLD = 4'h9,
    ST_SR_CLK  = 4'hA,
    ST_SR_EXIT = 4'hB,
    ST_SR_TRC  = 4'hC
  } sdis_state_e;

endpackage

/* File: logic/sdis_wait_cnt.sv */
`timescale 1ns/1ps
// Loadable down-counter; done is high while the count is zero
module sdis_wait_cnt #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  done_o
);

  logic [WIDTH-1:0] count;

  initial
  begin
    if (WIDTH < 2) $error("sdis_wait_cnt: WIDTH too small");
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count <= '0;
    else if (load_i)
      count <= value_i;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign done_o = (count == '0);

endmodule

/* File: tb/sdis_seq_chk.sv */
`timescale 1ns/1ps
module sdis_seq_chk
  import sdis_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = PWRUP_WAIT_CYC
) (
  input wire logic                CORE_CLK_I,
  input wire logic                RST_N_I,
  input wire logic                SD_CLK_EN_O,
  input wire logic                SD_CKE_O,
  input wire sdis_pkg::sdis_cmd_s SD_CMD_O,
  input wire logic [11:0]         SD_ADDR_O,
  input wire logic [1:0]          SD_DQM_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire idle_c = SD_CMD_O.cs_n |
    (SD_CMD_O.ras_n & SD_CMD_O.cas_n & SD_CMD_O.we_n);
  logic        seen;
  logic [15:0] cnt;
  // Counts the quiet power-up cycles up to the first command
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      seen <= 1'b0;
      cnt  <= '0;
    end
    else if (!seen)
    begin
      seen <= !idle_c;
      cnt  <= cnt + 16'h0001;
    end
  end
  sequence s_pre_gap;
    idle_c [*3] ##1 (SD_CMD_O == CMD_MRS);
  endsequence
  sequence s_exit_quiet;
    (SD_CKE_O && idle_c) [*6];
  endsequence
  chk_pwr_hold: assert property (!seen |-> SD_CKE_O && SD_CLK_EN_O
    && SD_DQM_O == 2'h3) else $error("power-up pins wrong");
  chk_pwr_wait: assert property (!seen && !idle_c
    |-> cnt >= PWRUP_CYC - 1) else $error("power-up pause short");
  chk_pre_first: assert property (!seen && !idle_c
    |-> SD_CMD_O == CMD_PRE && SD_ADDR_O[A10_POS])
    else $error("first command not precharge all");
  chk_mrs_gap: assert property (SD_CMD_O == CMD_PRE |=> s_pre_gap)
    else $error("mode set not after precharge gap");
  chk_ref_gap: assert property (SD_CMD_O == CMD_REF && SD_CKE_O
    |=> idle_c [*6]) else $error("refresh spacing short");
  chk_sr_entry: assert property ($fell(SD_CKE_O)
    |-> SD_CMD_O == CMD_REF) else $error("bad self-refresh entry");
  chk_sr_hold: assert property ($fell(SD_CKE_O) |=> !SD_CKE_O [*6])
    else $error("self-refresh left early");
  chk_clk_first: assert property ($rose(SD_CKE_O)
    |-> SD_CMD_O == CMD_DESEL && $past(SD_CLK_EN_O, 3))
    else $error("exit without stable clock or deselect");
  chk_exit_quiet: assert property ($rose(SD_CKE_O)
    |=> s_exit_quiet) else $error("command too soon after exit");
  chk_clk_off_cke: assert property (!SD_CLK_EN_O |-> !SD_CKE_O)
    else $error("clock stopped while CKE high");
endmodule
bind sdis_seq sdis_seq_chk #(.PWRUP_CYC(PWRUP_CYC)) chk_u (
  .CORE_CLK_I (CORE_CLK_I),
  .RST_N_I    (RST_N_I),
  .SD_CLK_EN_O(SD_CLK_EN_O),
  .SD_CKE_O   (SD_CKE_O),
  .SD_CMD_O   (SD_CMD_O),
  .SD_ADDR_O  (SD_ADDR_O),
  .SD_DQM_O   (SD_DQM_O)
);

/* File: tb/sdis_dev_model.sv */
`timescale 1ns/1ps
module sdis_dev_model
  import sdis_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                clk_en_i,
  input  wire logic                cke_i,
  input  wire sdis_pkg::sdis_cmd_s cmd_i,
  output logic                     in_sr_o,
  output logic [15:0]              bad_o
);
  logic cke_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cke_q   <= 1'b1;
      in_sr_o <= 1'b0;
      bad_o   <= '0;
    end
    else
    begin
      cke_q <= cke_i;
      if (cke_q && !cke_i && cmd_i == CMD_REF)
        in_sr_o <= 1'b1;
      else if (in_sr_o && cke_i)
        in_sr_o <= 1'b0;
      // A stopped clock with CKE high would lose the device's state
      if (!clk_en_i && cke_i)
        bad_o <= bad_o + 16'h0001;
    end
  end
endmodule

/* File: tb/sdis_seq_tb_top.sv */
`timescale 1ns/1ps
module sdis_seq_tb_top;
  import sdis_pkg::*;
  localparam int unsigned PW = 20;
  localparam int unsigned BR = 4;
  logic clk = 0, rst_n = 0, sr_in = 0, sr_out = 0, bref = 0;
  logic clk_en, cke, idone, sract, rdy, m_sr;
  logic [1:0] ba, dqm;
  logic [11:0] addr;
  logic [15:0] m_bad;
  sdis_cmd_s cmd;
  int err_total = 0;
  int compares = 0;
  always #4 clk = ~clk;
  sdis_seq #(.PWRUP_CYC(PW), .BURST_REFS(BR)) dut_u (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .SR_ENTER_I(sr_in),
    .SR_EXIT_I(sr_out), .BURST_REF_EN_I(bref), .SD_CLK_EN_O(clk_en),
    .SD_CKE_O(cke), .SD_CMD_O(cmd), .SD_BA_O(ba), .SD_ADDR_O(addr),
    .SD_DQM_O(dqm), .INIT_DONE_O(idone), .SR_ACTIVE_O(sract),
    .READY_O(rdy));
  sdis_dev_model dev_u (.clk_i(clk), .rst_n_i(rst_n), .clk_en_i(clk_en),
    .cke_i(cke), .cmd_i(cmd), .in_sr_o(m_sr), .bad_o(m_bad));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Counts refreshes (CKE high) until the stop condition holds
  task refs_until(input logic to_ready, output int r);
    int n;
    r = 0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (cmd === CMD_REF && cke === 1'b1)
        r++;
    end while (!(to_ready ? rdy === 1'b1 : cke === 1'b0) && n < 3000);
  endtask
  task t_init;
    int n;
    n = 0;
    @(posedge clk) sr_out <= 1'b1;
    do
    begin
      @(negedge clk);
      n++;
    end while (cmd === CMD_NOP && n < 500);
    chk(16'(n >= PW), 16'h0001);
    chk(16'(cmd), 16'(CMD_PRE));
    chk(16'(addr[A10_POS]), 16'h0001);
    chk(16'(dqm), 16'h0003);
    chk(16'(ba), 16'h0000);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (cmd !== CMD_MRS && n < 20);
    // One extra cycle: the sequencer hands over from its wait counter
    chk(16'(n), 16'(T_RP_CYC + 1));
    chk(16'(addr), 16'(MODE_WORD_RST));
    refs_until(1'b1, n);
    chk(16'(n), 16'(INIT_REF_CNT));
    chk(16'(idone), 16'h0001);
    @(posedge clk) sr_out <= 1'b0;
  endtask
  task t_sr(input logic burst);
    int n;
    @(posedge clk)
    begin
      bref <= burst;
      sr_in <= 1'b1;
    end
    refs_until(1'b0, n);
    chk(16'(n), burst ? 16'(BR) : 16'h0000);
    chk(16'(cmd), 16'(CMD_REF));
    // Exit asked at once; the sequencer must still honour tRAS
    @(posedge clk)
    begin
      sr_in <= 1'b0;
      sr_out <= 1'b1;
    end
    @(negedge clk);
    chk(16'(m_sr), 16'h0001);
    chk(16'({sract, clk_en}), 16'h0002);
    n = 1;
    while (cke !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(n > T_RAS_CYC), 16'h0001);
    chk(16'(cmd), 16'(CMD_DESEL));
    @(posedge clk) sr_out <= 1'b0;
    refs_until(1'b1, n);
    chk(16'(n), burst ? 16'(BR) : 16'h0000);
    chk(m_bad, 16'h0000);
  endtask
  task t_rst_mid;
    @(posedge clk) sr_in <= 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b0;
    sr_in <= 1'b0;
    @(negedge clk);
    chk(16'({cke, dqm}), 16'h0007);
    chk(16'(cmd), 16'(CMD_NOP));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_init;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_init;
    t_sr(1'b0);
    t_sr(1'b1);
    t_rst_mid;
    finish_test;
  end
  initial
  begin
    #200000;
    err_total++;
    finish_test;
  end
endmodule
